/* rtl/i2crm_regs.vh */
`ifndef I2CRM_REGS_VH
`define I2CRM_REGS_VH
`define I2CRM_SLV_ADDR 7'h50
`define I2CRM_ACK_SLOT 4'h8
`define I2CRM_BIT_ONE 4'h1
`define I2CRM_UPPER_BASE 8'h80
`define I2CRM_UPPER_TOP 8'hff
`define I2CRM_LOWER_BASE 8'h00
`define I2CRM_LOWER_TOP 8'h7f
`define I2CRM_ROW_AW 6
`define I2CRM_ROWS 64
`define I2CRM_LANE_ONE 2'h1
`define I2CRM_NVM_WRITE_TIME_US 10000
`define I2CRM_CLK_MHZ 100
`define I2CRM_CNT_W 24
`define I2CRM_CNT_LAST 24'h000001
`define I2CRM_NVM_CYCLES 24'h0f4240
`endif

/* rtl/i2crm_mem.v */
`timescale 1ns/100ps
`default_nettype none
`include "i2crm_regs.vh"
module i2crm_mem (
  input wire i_mclk,
  input wire i_we,
  input wire [`I2CRM_ROW_AW-1:0] i_waddr,
  input wire [31:0] i_wdata,
  input wire [`I2CRM_ROW_AW-1:0] i_raddr,
  output reg [31:0] o_rdata_q
);
  reg [31:0] mem [0:`I2CRM_ROWS-1];
  integer i;

  // blank array so reads before any programming are defined
  initial begin
    for (i = 0; i < `I2CRM_ROWS; i = i + 1) begin
      mem[i] = 32'h0000_0000;
    end
  end

  // one row word per entry, registered read
  always @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata_q <= mem[i_raddr];
  end
endmodule
`default_nettype wire

/* rtl/i2crm_top.v */
`timescale 1ns/100ps
`default_nettype none
`include "i2crm_regs.vh"
module i2crm_top #(
  parameter [`I2CRM_CNT_W-1:0] P_NVM_CYCLES = `I2CRM_NVM_CYCLES
) (
  input wire i_mclk,
  input wire i_rst,
  input wire i_scl,
  input wire i_sda,
  input wire i_chip_select_n,
  output reg o_sda_o,
  output reg o_sda_oe,
  output reg o_nvm_busy
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_DEVADDR = 3'h1;
  localparam [2:0] ST_MEMADDR = 3'h2;
  localparam [2:0] ST_WDATA = 3'h3;
  localparam [2:0] ST_RDATA = 3'h4;

  // byte lane of a row word, lane 0 at the low address
  function [7:0] lane_byte;
    input [31:0] word;
    input [1:0] idx;
    begin
      lane_byte = word[idx*8 +: 8];
    end
  endfunction

  // read counter advance, looping inside each memory table
  function [7:0] next_rd;
    input [7:0] a;
    begin
      if (a == `I2CRM_UPPER_TOP) begin
        next_rd = `I2CRM_UPPER_BASE;
      end else if (a == `I2CRM_LOWER_TOP) begin
        next_rd = `I2CRM_LOWER_BASE;
      end else begin
        next_rd = a + 8'h01;
      end
    end
  endfunction

  // two-flop synchronisers plus one delay stage for edges
  reg [1:0] scl_sync_q;
  reg [1:0] sda_sync_q;
  reg [1:0] cs_sync_q;
  reg scl_d_q;
  reg sda_d_q;

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      cs_sync_q <= 2'h3;
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], i_scl};
      sda_sync_q <= {sda_sync_q[0], i_sda};
      cs_sync_q <= {cs_sync_q[0], i_chip_select_n};
      scl_d_q <= scl_sync_q[1];
      sda_d_q <= sda_sync_q[1];
    end
  end

  wire scl_s = scl_sync_q[1];
  wire sda_s = sda_sync_q[1];
  wire cs_off = cs_sync_q[1];
  wire scl_rise = scl_s & ~scl_d_q;
  wire scl_fall = ~scl_s & scl_d_q;
  wire start_det = scl_s & scl_d_q & sda_d_q & ~sda_s;
  wire stop_det = scl_s & scl_d_q & ~sda_d_q & sda_s;

  // protocol state
  reg [2:0] state_q;
  reg [3:0] bit_cnt_q;
  reg in_ack_q;
  reg [7:0] shift_q;
  reg [7:0] tx_q;
  reg [7:0] ptr_q;
  // staged row and programming control
  reg [31:0] row_buf_q;
  reg [3:0] row_mask_q;
  reg [`I2CRM_ROW_AW-1:0] row_sel_q;
  reg pend_q;
  reg [`I2CRM_CNT_W-1:0] cnt_q;

  wire [31:0] mem_rdata;
  wire [31:0] merged;
  wire mem_we = o_nvm_busy & (cnt_q == `I2CRM_CNT_LAST);
  wire [`I2CRM_ROW_AW-1:0] mem_raddr = o_nvm_busy ? row_sel_q : ptr_q[7:2];
  wire addr_hit = (shift_q[7:1] == `I2CRM_SLV_ADDR);
  // byte at the read counter, taken when a read byte starts
  wire [7:0] rd_byte = lane_byte(mem_rdata, ptr_q[1:0]);

  // untouched lanes take the stored byte so the whole row is rewritten
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_merge
      assign merged[g*8 +: 8] = row_mask_q[g] ? row_buf_q[g*8 +: 8] : mem_rdata[g*8 +: 8];
    end
  endgenerate

  i2crm_mem u_mem (
    .i_mclk(i_mclk),
    .i_we(mem_we),
    .i_waddr(row_sel_q),
    .i_wdata(merged),
    .i_raddr(mem_raddr),
    .o_rdata_q(mem_rdata)
  );

  // open-drain pin only ever pulls low
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_sda_o <= 1'b0;
    end else begin
      o_sda_o <= 1'b0;
    end
  end

  // row programming timer, started by stop or a new start
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_nvm_busy <= 1'b0;
      cnt_q <= {`I2CRM_CNT_W{1'b0}};
    end else if (o_nvm_busy) begin
      cnt_q <= cnt_q - `I2CRM_CNT_LAST;
      if (cnt_q == `I2CRM_CNT_LAST) begin
        o_nvm_busy <= 1'b0;
      end
    end else if ((stop_det | start_det) & pend_q) begin
      o_nvm_busy <= 1'b1;
      cnt_q <= P_NVM_CYCLES;
    end
  end

  // byte engine: sampled on scl rise, driven on scl fall
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      in_ack_q <= 1'b0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      row_buf_q <= 32'h0000_0000;
      row_mask_q <= 4'h0;
      row_sel_q <= {`I2CRM_ROW_AW{1'b0}};
      pend_q <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      // staging closes when programming starts
      if ((stop_det | start_det) & pend_q & ~o_nvm_busy) begin
        pend_q <= 1'b0;
      end
      // lane marks stand until the merged row is in memory
      if (mem_we) begin
        row_mask_q <= 4'h0;
      end
      if (cs_off) begin
        state_q <= ST_IDLE;
        o_sda_oe <= 1'b0;
        in_ack_q <= 1'b0;
      end else if (start_det) begin
        state_q <= ST_DEVADDR;
        bit_cnt_q <= 4'h0;
        in_ack_q <= 1'b0;
        o_sda_oe <= 1'b0;
      end else if (stop_det) begin
        state_q <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end else if (state_q != ST_IDLE) begin
        if (scl_rise) begin
          if (bit_cnt_q != `I2CRM_ACK_SLOT) begin
            shift_q <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + `I2CRM_BIT_ONE;
          end else if (state_q == ST_RDATA && sda_s) begin
            state_q <= ST_IDLE;
          end
        end else if (scl_fall) begin
          if (bit_cnt_q == `I2CRM_ACK_SLOT && !in_ack_q) begin
            // a whole byte is in: decide and drive acknowledge
            in_ack_q <= 1'b1;
            case (state_q)
              ST_DEVADDR: begin
                if (addr_hit && !o_nvm_busy && !pend_q) begin
                  o_sda_oe <= 1'b1;
                  state_q <= shift_q[0] ? ST_RDATA : ST_MEMADDR;
                end else begin
                  o_sda_oe <= 1'b0;
                  state_q <= ST_IDLE;
                end
              end
              ST_MEMADDR: begin
                o_sda_oe <= 1'b1;
                ptr_q <= shift_q;
                row_sel_q <= shift_q[7:2];
                state_q <= ST_WDATA;
              end
              ST_WDATA: begin
                o_sda_oe <= 1'b1;
                row_buf_q[ptr_q[1:0]*8 +: 8] <= shift_q;
                row_mask_q[ptr_q[1:0]] <= 1'b1;
                pend_q <= 1'b1;
                ptr_q <= {ptr_q[7:2], ptr_q[1:0] + `I2CRM_LANE_ONE};
              end
              ST_RDATA: begin
                o_sda_oe <= 1'b0;
              end
              default: begin
                o_sda_oe <= 1'b0;
                state_q <= ST_IDLE;
              end
            endcase
          end else if (bit_cnt_q == `I2CRM_ACK_SLOT) begin
            // end of acknowledge slot: release or send next byte
            in_ack_q <= 1'b0;
            bit_cnt_q <= 4'h0;
            if (state_q == ST_RDATA) begin
              tx_q <= rd_byte;
              o_sda_oe <= ~rd_byte[7];
              ptr_q <= next_rd(ptr_q);
            end else begin
              o_sda_oe <= 1'b0;
            end
          end else if (state_q == ST_RDATA && bit_cnt_q != 4'h0) begin
            o_sda_oe <= ~tx_q[6];
            tx_q <= {tx_q[6:0], 1'b0};
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

/* sim/i2crm_master.sv */
`timescale 1ns/100ps
`default_nettype none
module i2crm_master (
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  // idle bus: clock stands high, data released
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // start or repeated start: data falls while clock high
  task automatic start();
    #10 o_sda = 1'b1;
    #20 o_scl = 1'b1;
    #20 o_sda = 1'b0;
    #20 o_scl = 1'b0;
  endtask
  // stop: data rises while clock high, clock then stands
  task automatic stop();
    #10 o_sda = 1'b0;
    #20 o_scl = 1'b1;
    #20 o_sda = 1'b1;
    #40;
  endtask
  // nine bits msb first, each sampled from the wire at clock high
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      #10 o_sda = tx[i];
      #30 o_scl = 1'b1;
      #20 rx[i] = i_sda;
      #20 o_scl = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* sim/i2crm_top_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
`include "i2crm_regs.vh"
module i2crm_top_asserts #(
  parameter [`I2CRM_CNT_W-1:0] P_NVM_CYCLES = 24'h0000c8
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_chip_select_n,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  input wire logic o_nvm_busy
);
  logic [`I2CRM_CNT_W-1:0] busy_cnt_q;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // cycles the programming flag has stood
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) busy_cnt_q <= 24'h000000;
    else busy_cnt_q <= o_nvm_busy ? busy_cnt_q + 24'h000001 : 24'h000000;
  end
  // properties on the data line and programming flag
  sequence s_scl_rise; !i_scl ##1 i_scl; endsequence
  property p_sda_o_zero; o_sda_o == 1'b0; endproperty
  a_sda_o_zero: assert property (p_sda_o_zero) else $error("drive value not zero");
  property p_desel_idle; i_chip_select_n [*4] |-> !o_sda_oe; endproperty
  a_desel_idle: assert property (p_desel_idle) else $error("driving while deselected");
  property p_busy_quiet; o_nvm_busy |-> !o_sda_oe; endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("acknowledge while busy");
  property p_busy_len; $fell(o_nvm_busy) |-> busy_cnt_q == P_NVM_CYCLES; endproperty
  a_busy_len: assert property (p_busy_len) else $error("programming time wrong");
  property p_busy_at_stop; $rose(o_nvm_busy) |-> i_scl; endproperty
  a_busy_at_stop: assert property (p_busy_at_stop) else $error("programming not at stop");
  property p_oe_after_fall; $rose(o_sda_oe) |-> !$past(i_scl, 2); endproperty
  a_oe_after_fall: assert property (p_oe_after_fall) else $error("drive not after clock fall");
  property p_oe_hold_high; s_scl_rise |-> ##1 $stable(o_sda_oe) [*3]; endproperty
  a_oe_hold_high: assert property (p_oe_hold_high) else $error("drive changed in clock high");
  property p_rst_idle; $fell(i_rst) |-> !o_sda_oe && !o_nvm_busy; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
endmodule
bind i2crm_top i2crm_top_asserts #(.P_NVM_CYCLES(P_NVM_CYCLES)) i_chk (.i_mclk(i_mclk), .i_rst(i_rst),
  .i_scl(i_scl), .i_sda(i_sda), .i_chip_select_n(i_chip_select_n), .o_sda_o(o_sda_o),
  .o_sda_oe(o_sda_oe), .o_nvm_busy(o_nvm_busy));
`default_nettype wire

/* sim/tb_i2c_row_memory_access.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_i2c_row_memory_access;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic cs_n = 1'b0;
  logic scl, sda_m, sda_o, sda_oe, busy;
  logic [8:0] rx;
  wire sda_w = sda_m & ~sda_oe;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #5 i_mclk = ~i_mclk;
  i2crm_top #(.P_NVM_CYCLES(24'h0000c8)) i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda_w),
    .i_chip_select_n(cs_n), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_nvm_busy(busy));
  i2crm_master i_mst (.i_sda(sda_w), .o_scl(scl), .o_sda(sda_m));
  // compare, count and report
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // one written byte and its acknowledge
  task automatic tx(input logic [7:0] b, input logic ack);
    i_mst.xfer({b, 1'b1}, rx);
    chk("ack", {7'h00, !ack}, {7'h00, rx[0]});
  endtask
  // write transaction, then poll until the address is acknowledged
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input int n);
    int polls;
    polls = 0;
    i_mst.start();
    tx(8'ha0, 1'b1);
    tx(a, 1'b1);
    for (int i = 0; i < n; i++) tx(d[31-8*i -: 8], 1'b1);
    i_mst.stop();
    chk("busy after stop", 8'h01, {7'h00, busy});
    do begin
      i_mst.start();
      i_mst.xfer(9'h141, rx);
      i_mst.stop();
      polls++;
    end while (rx[0] && polls < 40);
    chk("first poll nack", 8'h01, {7'h00, polls > 1});
    chk("poll ack", 8'h00, {7'h00, rx[0]});
  endtask
  // optional address setting, then n bytes read
  task automatic rd(input logic dummy, input logic [7:0] a, input int n, input logic [31:0] e);
    i_mst.start();
    if (dummy) begin
      tx(8'ha0, 1'b1);
      tx(a, 1'b1);
      i_mst.start();
    end
    tx(8'ha1, 1'b1);
    for (int i = 0; i < n; i++) begin
      i_mst.xfer({8'hff, i == n - 1}, rx);
      chk("read byte", e[31-8*i -: 8], rx[8:1]);
    end
    i_mst.stop();
  endtask
  // full row, partial row, wrapped row, then current address read
  task automatic t_row();
    wr(8'h84, 32'h11223344, 4);
    rd(1'b1, 8'h84, 4, 32'h11223344);
    wr(8'h85, 32'h99000000, 1);
    rd(1'b1, 8'h84, 4, 32'h11993344);
    wr(8'h86, 32'h55667700, 3);
    rd(1'b0, 8'h00, 1, 32'h99000000);
    rd(1'b1, 8'h84, 4, 32'h77995566);
  endtask
  // read across the top of the upper table, then across the top of the lower table
  task automatic t_wrap();
    wr(8'hfc, 32'ha1a2a3a4, 4);
    wr(8'h80, 32'hb1b2b3b4, 4);
    rd(1'b1, 8'hff, 2, 32'ha4b10000);
    wr(8'h7c, 32'hc1c2c3c4, 4);
    wr(8'h00, 32'hd1d2d3d4, 4);
    rd(1'b1, 8'h7f, 2, 32'hc4d10000);
  endtask
  // foreign address, following byte, then deselected device
  task automatic t_refuse();
    i_mst.start();
    tx(8'ha2, 1'b0);
    tx(8'ha0, 1'b0);
    i_mst.stop();
    cs_n = 1'b1;
    i_mst.start();
    tx(8'ha0, 1'b0);
    i_mst.stop();
    cs_n = 1'b0;
    chk("drive value", 8'h00, {7'h00, sda_o});
  endtask
  // reset, scenarios, verdict
  initial begin
    repeat (4) @(posedge i_mclk);
    @(negedge i_mclk) i_rst = 1'b0;
    repeat (3) @(negedge i_mclk);
    t_row();
    t_wrap();
    t_refuse();
    give_verdict();
  end
  // hang limit
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      give_verdict();
    end
  end
endmodule
`default_nettype wire
